// >>> apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module apb_host_model (
  // clock
  input wire logic pclk,
  // apb master side
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // request held until pready is seen at a rising edge, or dropped after 20 edges without it
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e, output logic to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    to = (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host_model

`default_nettype wire

// >>> dac_pd_pkg.sv
`default_nettype none

package dac_pd_pkg;

  // register map, one aligned word each
  localparam logic [7:0] ADDR_BYTE = 8'h00;
  localparam logic [7:0] ADDR_READBACK = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;

  // control word layout
  localparam int WORD_W = 16;
  localparam int DATA_W = 12;
  localparam int MODE_HI_POS = 13;
  localparam int MODE_LO_POS = 12;
  localparam int DATA_MSB = 11;
  localparam int BYTE_W = 8;

  // ctrl register bits
  localparam int CTRL_LOW_SUPPLY_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;

  // status register fields
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_MODE_LSB = 2;
  localparam int STAT_PENDING_BIT = 4;
  localparam int STAT_ADDR_LSB = 5;

  // values after reset
  localparam logic [DATA_W-1:0] CODE_RESET = 12'h000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] SLAVE_ADDR_BASE = 5'h03;

  // wake-up delay, least times rounded up to whole cycles
  localparam int CLK_PERIOD_PS = 10000;
  localparam int WAKE_5V_PS = 2500000;
  localparam int WAKE_3V_PS = 6000000;
  localparam logic [9:0] WAKE_5V_CYC = 10'((WAKE_5V_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [9:0] WAKE_3V_CYC = 10'((WAKE_3V_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PD_1K = 2'b01,
    MODE_PD_100K = 2'b10,
    MODE_PD_3STATE = 2'b11
  } pd_mode_e;

  typedef enum logic {
    GRP_FIRST = 1'b0,
    GRP_SECOND = 1'b1
  } grp_state_e;

  // enables for the analog side
  typedef struct packed {
    logic bias_en;
    logic amp_en;
    logic string_en;
    logic out_connect;
    logic term_1k;
    logic term_100k;
  } analog_ctl_s;

endpackage : dac_pd_pkg

`default_nettype wire

// >>> dac_power_down_control.sv
// How it works
// - mode comes from word bits 13 and 12
// - 00 normal, 01 1k, 10 100k, 11 three-state
// - low sleep pin forces three-state power-down
// - power-down disables analog; 1k and 100k put output onto termination, three-state leaves it open
// - power-down never alters stored DAC code
// - output valid only after wake-up delay
// - strap pins give each device distinct address
// - word: two ignored, two mode, data
// - DAC code cleared to zero at reset
// - readback returns data and mode bits
`timescale 1ns/1ps
`default_nettype none

module dac_power_down_control
  import dac_pd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic force_sleep_n_pin,
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  // analog side
  output analog_ctl_s analog_ctl,
  output logic [DATA_W-1:0] dac_code,
  output logic output_valid
);

  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == ADDR_BYTE) || (addr == ADDR_READBACK) ||
              (addr == ADDR_STATUS) || (addr == ADDR_CTRL);
  endfunction : reg_hit

  function automatic analog_ctl_s decode_mode(input pd_mode_e mode);
    analog_ctl_s c;
    c = '0;
    case (mode)
      MODE_NORMAL: begin
        c.bias_en = 1'b1;
        c.amp_en = 1'b1;
        c.string_en = 1'b1;
        c.out_connect = 1'b1;
      end
      MODE_PD_1K: c.term_1k = 1'b1;
      MODE_PD_100K: c.term_100k = 1'b1;
      MODE_PD_3STATE: c = '0;
      default: c = '0;
    endcase
    decode_mode = c;
  endfunction : decode_mode

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic sleep_meta_ff;
  logic sleep_sync_n_ff;
  logic [1:0] strap_meta_ff;
  logic [1:0] strap_sync_ff;
  logic [6:0] slave_addr_ff;
  grp_state_e grp_ff;
  logic [BYTE_W-1:0] hi_byte_ff;
  pd_mode_e sw_mode_ff;
  logic [DATA_W-1:0] code_ff;
  logic low_supply_ff;
  analog_ctl_s ctl_ff;
  logic [9:0] wake_cnt_ff;
  logic output_valid_ff;

  logic setup_phase;
  logic apb_done;
  logic wr_done;
  logic byte_wr;
  logic commit;
  logic [WORD_W-1:0] word;
  pd_mode_e eff_mode;
  logic [9:0] wake_limit;
  logic [31:0] nxt_prdata;

  // one wait state: answer is registered in the first access cycle
  assign setup_phase = psel && penable && !pready_ff;
  assign apb_done = psel && penable && pready_ff;
  assign wr_done = apb_done && pwrite;
  assign byte_wr = wr_done && (paddr == ADDR_BYTE);
  assign commit = byte_wr && (grp_ff == GRP_SECOND);
  assign word = {hi_byte_ff, pwdata[BYTE_W-1:0]};
  assign eff_mode = sleep_sync_n_ff ? sw_mode_ff : MODE_PD_3STATE;
  assign wake_limit = low_supply_ff ? WAKE_3V_CYC : WAKE_5V_CYC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup_phase;
      pslverr_ff <= setup_phase && !reg_hit(paddr);
      if (setup_phase) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (!pwrite) begin
      case (paddr)
        ADDR_READBACK: nxt_prdata[WORD_W-1:0] = {2'b00, sw_mode_ff, code_ff};
        ADDR_STATUS: begin
          nxt_prdata[STAT_SLEEP_BIT] = (eff_mode != MODE_NORMAL);
          nxt_prdata[STAT_VALID_BIT] = output_valid_ff;
          nxt_prdata[STAT_MODE_LSB +: 2] = eff_mode;
          nxt_prdata[STAT_PENDING_BIT] = (grp_ff == GRP_SECOND);
          nxt_prdata[STAT_ADDR_LSB +: 7] = slave_addr_ff;
        end
        ADDR_CTRL: nxt_prdata[CTRL_LOW_SUPPLY_BIT] = low_supply_ff;
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_meta_ff <= 1'b1;
      sleep_sync_n_ff <= 1'b1;
      strap_meta_ff <= 2'b00;
      strap_sync_ff <= 2'b00;
    end else begin
      sleep_meta_ff <= force_sleep_n_pin;
      sleep_sync_n_ff <= sleep_meta_ff;
      strap_meta_ff <= {addr_strap_1, addr_strap_0};
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // straps tracked continuously, not caught under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_addr_ff <= {SLAVE_ADDR_BASE, 2'b00};
    end else begin
      slave_addr_ff <= {SLAVE_ADDR_BASE, strap_sync_ff};
    end
  end

  // byte pairing; ctrl restart drops a half-written word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_ff <= GRP_FIRST;
      hi_byte_ff <= BYTE_RESET;
    end else if (byte_wr) begin
      case (grp_ff)
        GRP_FIRST: begin
          hi_byte_ff <= pwdata[BYTE_W-1:0];
          grp_ff <= GRP_SECOND;
        end
        GRP_SECOND: grp_ff <= GRP_FIRST;
        default: grp_ff <= GRP_FIRST;
      endcase
    end else if (wr_done && (paddr == ADDR_CTRL) && pwdata[CTRL_RESTART_BIT]) begin
      grp_ff <= GRP_FIRST;
    end
  end

  // code survives any power-down, only a full word moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_mode_ff <= MODE_NORMAL;
      code_ff <= CODE_RESET;
    end else if (commit) begin
      sw_mode_ff <= pd_mode_e'(word[MODE_HI_POS:MODE_LO_POS]);
      code_ff <= word[DATA_MSB:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_supply_ff <= 1'b0;
    end else if (wr_done && (paddr == ADDR_CTRL)) begin
      low_supply_ff <= pwdata[CTRL_LOW_SUPPLY_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= '0;
    end else begin
      ctl_ff <= decode_mode(eff_mode);
    end
  end

  // wake timer restarts on every power-down, including reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_ff <= 10'h000;
      output_valid_ff <= 1'b0;
    end else if (eff_mode != MODE_NORMAL) begin
      wake_cnt_ff <= 10'h000;
      output_valid_ff <= 1'b0;
    end else begin
      if (wake_cnt_ff < wake_limit) begin
        wake_cnt_ff <= wake_cnt_ff + 10'h001;
      end
      output_valid_ff <= (wake_cnt_ff >= wake_limit);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign analog_ctl = ctl_ff;
  assign dac_code = code_ff;
  assign output_valid = output_valid_ff;

  property p_commit_mode;
    @(posedge pclk) disable iff (!presetn)
      commit |=> sw_mode_ff == pd_mode_e'($past(hi_byte_ff[5:4]));
  endproperty
  a_commit_mode: assert property (p_commit_mode)
    else $error("mode bits not taken from word bits 13 and 12");

  property p_first_byte_holds;
    @(posedge pclk) disable iff (!presetn)
      (byte_wr && grp_ff == GRP_FIRST) |=> $stable(code_ff) && $stable(sw_mode_ff);
  endproperty
  a_first_byte_holds: assert property (p_first_byte_holds)
    else $error("first byte changed mode or code");

  property p_pin_override;
    @(posedge pclk) disable iff (!presetn)
      !sleep_sync_n_ff |=> ctl_ff == '0;
  endproperty
  a_pin_override: assert property (p_pin_override)
    else $error("sleep pin did not force three-state");

  property p_decode_pd;
    @(posedge pclk) disable iff (!presetn)
      (eff_mode == MODE_PD_1K) |=> ctl_ff.term_1k && !ctl_ff.term_100k && !ctl_ff.amp_en;
  endproperty
  a_decode_pd: assert property (p_decode_pd)
    else $error("1k power-down decoded wrongly");

  property p_sleep_analog_off;
    @(posedge pclk) disable iff (!presetn)
      (eff_mode != MODE_NORMAL) |=> !ctl_ff.bias_en && !ctl_ff.string_en && !ctl_ff.out_connect;
  endproperty
  a_sleep_analog_off: assert property (p_sleep_analog_off)
    else $error("analog left on in power-down");

  property p_code_kept;
    @(posedge pclk) disable iff (!presetn)
      !commit |=> $stable(code_ff);
  endproperty
  a_code_kept: assert property (p_code_kept)
    else $error("dac code moved without a word");

  property p_wake_time;
    @(posedge pclk) disable iff (!presetn)
      $rose(output_valid_ff) |-> $past(wake_cnt_ff) == (low_supply_ff ? WAKE_3V_CYC : WAKE_5V_CYC);
  endproperty
  a_wake_time: assert property (p_wake_time)
    else $error("output valid before wake-up delay");

  property p_readback;
    @(posedge pclk) disable iff (!presetn)
      (apb_done && !pwrite && paddr == ADDR_READBACK) |-> prdata_ff[13:0] == {sw_mode_ff, code_ff};
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback lost mode or data");

  property p_strap;
    @(posedge pclk) disable iff (!presetn)
      ##1 slave_addr_ff == {SLAVE_ADDR_BASE, $past(strap_sync_ff)};
  endproperty
  a_strap: assert property (p_strap)
    else $error("slave address does not follow straps");

  property p_reset_code;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> code_ff == CODE_RESET;
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("code not zero after reset");

  property p_decode_100k;
    @(posedge pclk) disable iff (!presetn)
      (eff_mode == MODE_PD_100K) |=> ctl_ff.term_100k && !ctl_ff.term_1k && !ctl_ff.amp_en;
  endproperty
  a_decode_100k: assert property (p_decode_100k)
    else $error("100k power-down decoded wrongly");

  // normal mode must drive the pin from the amplifier, no termination
  property p_normal_drive;
    @(posedge pclk) disable iff (!presetn)
      (eff_mode == MODE_NORMAL) |=> ctl_ff.bias_en && ctl_ff.amp_en && ctl_ff.out_connect &&
        !ctl_ff.term_1k && !ctl_ff.term_100k;
  endproperty
  a_normal_drive: assert property (p_normal_drive)
    else $error("normal mode decoded wrongly");

  property p_sleep_not_valid;
    @(posedge pclk) disable iff (!presetn)
      (eff_mode != MODE_NORMAL) |=> !output_valid_ff;
  endproperty
  a_sleep_not_valid: assert property (p_sleep_not_valid)
    else $error("output valid during power-down");

endmodule : dac_power_down_control

`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import dac_pd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, output_valid, err, to;
  logic force_sleep_n_pin = 1'b1;
  logic addr_strap_0 = 1'b0;
  logic addr_strap_1 = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [DATA_W-1:0] dac_code;
  analog_ctl_s analog_ctl;
  logic [5:0] exp_ctl [4] = '{6'h3c, 6'h02, 6'h01, 6'h00};
  logic [15:0] word;
  int fails, checks_done, n;

  always #5 pclk = ~pclk;

  apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  dac_power_down_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .force_sleep_n_pin(force_sleep_n_pin),
    .addr_strap_0(addr_strap_0), .addr_strap_1(addr_strap_1), .analog_ctl(analog_ctl),
    .dac_code(dac_code), .output_valid(output_valid));

  task final_report;
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rv, err, to);
    if (to) begin
      fails++;
      final_report();
    end
  endtask : bus

  // bytes go high first, as the serial word does
  task put_word(input logic [15:0] w);
    bus(1'b1, ADDR_BYTE, {24'h0, w[15:8]});
    bus(1'b1, ADDR_BYTE, {24'h0, w[7:0]});
  endtask : put_word

  task wait_valid(input int lo, input int hi);
    for (n = 0; n < 1000 && output_valid !== 1'b1; n++) begin
      @(posedge pclk);
    end
    chk("wake", 1, n >= lo && n <= hi);
    // a wait that used up its bound ends the run
    if (n >= 1000) begin
      final_report();
    end
  endtask : wait_valid

  initial begin
    repeat (5) @(posedge pclk);
    chk("code_rst", 0, dac_code);
    presetn <= 1'b1;
    wait_valid(250, 270);
    bus(1'b0, ADDR_READBACK, 0);
    chk("rb_rst", 0, rv);
    for (int m = 0; m < 4; m++) begin
      word = {2'b11, m[1:0], 12'ha5c ^ 12'(m)};
      bus(1'b1, ADDR_BYTE, {24'h0, word[15:8]});
      repeat (2) @(posedge pclk);
      chk("half", m == 0 ? 0 : 12'ha5c ^ 12'(m - 1), dac_code);
      bus(1'b1, ADDR_BYTE, {24'h0, word[7:0]});
      repeat (3) @(posedge pclk);
      chk("code", word[11:0], dac_code);
      chk("analog", exp_ctl[m], analog_ctl);
      bus(1'b0, ADDR_READBACK, 0);
      chk("rb", {18'h0, word[13:0]}, rv);
      bus(1'b0, ADDR_STATUS, 0);
      chk("st_mode", m, rv[3:2]);
    end
    put_word(16'hc123);
    wait_valid(245, 270);
    force_sleep_n_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("pin_ctl", 0, analog_ctl);
    chk("pin_code", 12'h123, dac_code);
    chk("pin_valid", 0, output_valid);
    bus(1'b0, ADDR_STATUS, 0);
    chk("st_sleep", 1, rv[0]);
    bus(1'b1, ADDR_CTRL, 1);
    force_sleep_n_pin <= 1'b1;
    wait_valid(600, 620);
    bus(1'b1, ADDR_BYTE, 32'h2f);
    bus(1'b0, ADDR_STATUS, 0);
    chk("pend", 1, rv[4]);
    bus(1'b1, ADDR_CTRL, 3);
    bus(1'b0, ADDR_CTRL, 0);
    chk("ctrl", 1, rv);
    put_word(16'h0abc);
    repeat (3) @(posedge pclk);
    chk("restart", 12'habc, dac_code);
    bus(1'b0, ADDR_BYTE, 0);
    chk("byte_rd", 0, rv);
    bus(1'b0, 8'h10, 0);
    chk("bad_rd", 1, {rv != 0, err});
    for (int s = 0; s < 4; s++) begin
      addr_strap_0 <= s[0];
      addr_strap_1 <= s[1];
      repeat (4) @(posedge pclk);
      bus(1'b0, ADDR_STATUS, 0);
      chk("slave", {5'h03, s[1:0]}, rv[11:5]);
    end
    final_report();
  end
endmodule : testbench

`default_nettype wire
